// >>> inc/adcc_pkg.sv
package adcc_pkg;

    // ************************************************
    // Widths
    // ************************************************
    localparam int ADCC_RES_W = 10;
    localparam int ADCC_CH_W = 4;
    localparam int ADCC_NUM_EVT = 2;

    // ************************************************
    // Register byte offsets
    // ************************************************
    localparam logic [7:0] ADCC_OFF_CSR = 8'h00;
    localparam logic [7:0] ADCC_OFF_HIGH = 8'h04;
    localparam logic [7:0] ADCC_OFF_LOW = 8'h08;
    localparam logic [7:0] ADCC_OFF_ISR = 8'h0c;
    localparam logic [7:0] ADCC_OFF_IMR = 8'h10;

    // ************************************************
    // Control/status fields
    // ************************************************
    localparam int ADCC_BIT_EOC = 7;
    localparam int ADCC_BIT_SPEED = 6;
    localparam int ADCC_BIT_ON = 5;
    localparam int ADCC_BIT_RSV = 4;
    localparam int ADCC_CH_LSB = 0;

    // Interrupt status bits
    localparam int ADCC_EVT_EOC = 0;
    localparam int ADCC_EVT_ABORT = 1;

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [7:0] ADCC_CSR_RST = 8'h00;
    localparam logic [7:0] ADCC_HIGH_RST = 8'h00;
    localparam logic [1:0] ADCC_LOW_RST = 2'h0;
    localparam logic [1:0] ADCC_MASK_RST = 2'h0;

    // ************************************************
    // Converter clock divide ratios
    // ************************************************
    localparam logic [1:0] ADCC_DIV_SLOW_LAST = 2'h3;
    localparam logic [1:0] ADCC_DIV_FAST_LAST = 2'h1;

    typedef enum logic [1:0]
    {
        ADCC_IDLE = 2'b00,
        ADCC_START = 2'b01,
        ADCC_BUSY = 2'b10
    } adcc_conv_t;

endpackage

// >>> verilog/adcc_clkdiv.sv
`timescale 1ns/1ps

module adcc_clkdiv
    import adcc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Control
    input wire logic enable,
    input wire logic half_rate,
    // Converter clock strobe
    output logic tick
);

    logic [1:0] cnt;
    logic [1:0] last;

    // Divide by two or by four of the CPU clock
    assign last = half_rate ? ADCC_DIV_FAST_LAST : ADCC_DIV_SLOW_LAST; // R4

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= 2'h0;
            tick <= 1'b0;
        end
        else if (ce)
        begin
            if (!enable || cnt >= last)
            begin
                cnt <= 2'h0;
            end
            else
            begin
                cnt <= cnt + 2'h1;
            end
            tick <= enable && (cnt == last);
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    a_div_fast: assert property ( // R4
        @(posedge hclk) disable iff (!hresetn)
        (tick && half_rate && enable && ce) ##1 (ce && half_rate && enable)
            ##1 (ce && half_rate) |-> tick)
        else $error("fast converter clock not every second cycle");

endmodule // adcc_clkdiv

// >>> verilog/adcc_regs.sv
`timescale 1ns/1ps

// How it works
// R1: Conversion-complete flag in control bit 7 is set when a conversion ends.
// R2: Reading the high result or writing control clears the complete flag.
// R3: Complete flag is read-only; every other control bit is read/write.
// R4: Speed bit picks converter clock: 0 is CPU/4, 1 is CPU/2.
// R5: Writing converter-on as 1 starts conversion; 0 stops and disables.
// R6: Software always writes zero to reserved control bit 4.
// R7: Four low control bits select input 0 to 15 as binary index.
// R8: Number of real input channels is a parameter, at most sixteen.
// R9: High result register holds result bits 9 down to 2.
// R10: Low result register holds result bits 1 and 0 in bits 1:0.
// R11: Upper six bits of the low result register always read zero.
// R12: Control and both result registers reset to zero.
// R13: Results update in the same cycle the complete flag is set.
// R14: Clearing converter-on mid-conversion abandons it: no flag, no result.

module adcc_regs
    import adcc_pkg::*;
#(
    parameter int NUM_CH = 16
)
(
    // AHB-Lite clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt
    output logic irq,
    // Conversion core
    output logic converter_on,
    output logic core_start,
    output logic core_clk_tick,
    output logic [ADCC_CH_W-1:0] input_channel_select,
    output logic core_channel_valid,
    input wire logic core_done,
    input wire logic [ADCC_RES_W-1:0] core_result
);

    // ************************************************
    // Declarations
    // ************************************************
    logic pend;
    logic acc_write;
    logic [7:0] acc_addr;
    logic acc_go;
    logic data_go;
    logic wr_go;
    logic rd_go;
    logic wr_csr;
    logic wr_imr;
    logic rd_high;
    logic rd_isr;
    logic eoc;
    logic speed;
    logic rsv;
    logic [7:0] result_high_byte;
    logic [1:0] result_low_bits;
    logic [ADCC_NUM_EVT-1:0] isr;
    logic [ADCC_NUM_EVT-1:0] imr;
    logic [ADCC_NUM_EVT-1:0] evt;
    logic [7:0] rd_val;
    logic start_req;
    logic stop_req;
    logic conv_finish;
    logic conv_abort;
    adcc_conv_t state;
    adcc_conv_t next_state;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ************************************************
    // Bus address and data phase
    // ************************************************
    assign acc_go = ce && hsel && hready && htrans[1];
    assign data_go = ce && pend;
    assign wr_go = data_go && acc_write;
    assign rd_go = data_go && !acc_write;
    assign wr_csr = wr_go && hit(acc_addr, ADCC_OFF_CSR);
    assign wr_imr = wr_go && hit(acc_addr, ADCC_OFF_IMR);
    assign rd_high = rd_go && hit(acc_addr, ADCC_OFF_HIGH);
    assign rd_isr = rd_go && hit(acc_addr, ADCC_OFF_ISR);

    // One wait state so that read data comes from a flip-flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend <= 1'b0;
            acc_write <= 1'b0;
            acc_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            hresp <= 1'b0;
            if (acc_go)
            begin
                pend <= 1'b1;
                acc_write <= hwrite;
                acc_addr <= haddr[7:0];
                hreadyout <= 1'b0;
            end
            else if (pend)
            begin
                pend <= 1'b0;
                hreadyout <= 1'b1;
            end
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb
    begin
        rd_val = 8'h00;
        case (acc_addr)
            ADCC_OFF_CSR: rd_val =
                {eoc, speed, converter_on, rsv, input_channel_select};
            ADCC_OFF_HIGH: rd_val = result_high_byte; // R9
            ADCC_OFF_LOW: rd_val = {6'h00, result_low_bits}; // R10 R11
            ADCC_OFF_ISR: rd_val = {6'h00, isr};
            ADCC_OFF_IMR: rd_val = {6'h00, imr};
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rd_go)
        begin
            hrdata <= {24'h00_0000, rd_val};
        end
    end

    // ************************************************
    // Control/status register
    // ************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            speed <= ADCC_CSR_RST[ADCC_BIT_SPEED]; // R12
            converter_on <= ADCC_CSR_RST[ADCC_BIT_ON];
            rsv <= ADCC_CSR_RST[ADCC_BIT_RSV];
            input_channel_select <= ADCC_CSR_RST[ADCC_CH_W-1:0];
            core_channel_valid <= 1'b1;
        end
        else if (wr_csr)
        begin
            speed <= hwdata[ADCC_BIT_SPEED]; // R3 R4
            converter_on <= hwdata[ADCC_BIT_ON]; // R5
            rsv <= hwdata[ADCC_BIT_RSV];
            input_channel_select <= hwdata[ADCC_CH_LSB+:ADCC_CH_W]; // R7
            core_channel_valid <=
                {1'b0, hwdata[ADCC_CH_LSB+:ADCC_CH_W]} < 5'(NUM_CH); // R8
        end
    end

    // ************************************************
    // Conversion sequencer
    // ************************************************
    assign start_req = wr_csr && hwdata[ADCC_BIT_ON];
    assign stop_req = wr_csr && !hwdata[ADCC_BIT_ON];
    assign conv_finish = ce && state == ADCC_BUSY && core_done && !stop_req;
    assign conv_abort = ce && state != ADCC_IDLE && stop_req; // R14

    always_comb
    begin
        next_state = state;
        unique case (state)
            ADCC_IDLE:
            begin
                if (start_req)
                begin
                    next_state = ADCC_START; // R5
                end
            end
            ADCC_START:
            begin
                next_state = stop_req ? ADCC_IDLE : ADCC_BUSY;
            end
            ADCC_BUSY:
            begin
                if (stop_req || core_done)
                begin
                    next_state = ADCC_IDLE; // R14
                end
            end
            default:
            begin
                next_state = ADCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ADCC_IDLE;
            core_start <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            core_start <= next_state == ADCC_START;
        end
    end

    adcc_clkdiv u_clkdiv
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .enable(converter_on),
        .half_rate(speed),
        .tick(core_clk_tick)
    );

    // ************************************************
    // Completion flag and results
    // ************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            eoc <= ADCC_CSR_RST[ADCC_BIT_EOC];
        end
        else if (conv_finish)
        begin
            eoc <= 1'b1; // R1
        end
        else if (wr_csr || rd_high)
        begin
            eoc <= 1'b0; // R2
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            result_high_byte <= ADCC_HIGH_RST; // R12
            result_low_bits <= ADCC_LOW_RST;
        end
        else if (conv_finish)
        begin
            result_high_byte <= core_result[9:2]; // R13 R9
            result_low_bits <= core_result[1:0]; // R10
        end
    end

    // ************************************************
    // Interrupt status and mask
    // ************************************************
    assign evt[ADCC_EVT_EOC] = conv_finish;
    assign evt[ADCC_EVT_ABORT] = conv_abort;

    generate
        for (genvar gi = 0; gi < ADCC_NUM_EVT; gi++)
        begin : g_isr
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    isr[gi] <= 1'b0;
                end
                else if (evt[gi])
                begin
                    isr[gi] <= 1'b1;
                end
                else if (rd_isr)
                begin
                    isr[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            imr <= ADCC_MASK_RST;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_imr)
            begin
                imr <= hwdata[ADCC_NUM_EVT-1:0];
            end
            irq <= |(isr & imr);
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_start_req;
        start_req && state == ADCC_IDLE;
    endsequence
    sequence s_start_pulse;
        core_start ##1 (!core_start && state == ADCC_BUSY);
    endsequence
    sequence s_bus_take;
        acc_go && !pend;
    endsequence
    sequence s_bus_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    a_eoc_set_result: assert property ( // R1
        conv_finish |=> eoc && result_high_byte == $past(core_result[9:2])
            && result_low_bits == $past(core_result[1:0]))
        else $error("complete flag or result not updated together");
    a_eoc_clear_read: assert property ( // R2
        rd_high && !conv_finish |=> !eoc)
        else $error("high result read did not clear complete flag");
    a_eoc_read_only: assert property ( // R3
        wr_csr && hwdata[ADCC_BIT_EOC] && !conv_finish |=> !eoc)
        else $error("software write set complete flag");
    a_start_pulse: assert property ( // R5
        s_start_req ##0 !stop_req |=> s_start_pulse)
        else $error("start did not give a single start pulse");
    a_chan_select: assert property ( // R7
        wr_csr |=> input_channel_select == $past(hwdata[3:0]))
        else $error("channel field not taken from write");
    a_low_zero: assert property ( // R11
        $rose(hreadyout) && $past(hit(acc_addr, ADCC_OFF_LOW))
            && $past(!acc_write) |-> hrdata[31:2] == 30'h0)
        else $error("low result upper bits not zero");
    a_high_map: assert property ( // R9
        rd_high |=> hrdata[7:0] == $past(result_high_byte))
        else $error("high result read wrong value");
    a_abandon_conv: assert property ( // R14
        conv_abort |=> state == ADCC_IDLE && !eoc && $stable(result_high_byte))
        else $error("abandoned conversion still completed");
    a_bus_wait: assert property (
        s_bus_take |=> s_bus_answer)
        else $error("bus answer not after one wait state");
    a_irq_level: assert property (
        ce && |(isr & imr) |=> irq)
        else $error("unmasked status did not raise interrupt");
endmodule // adcc_regs

// >>> verification/adcc_core_model.sv
`timescale 1ns/1ps

module adcc_core_model
    import adcc_pkg::*;
#(
    parameter int TICKS = 6
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control from the register block
    input wire logic converter_on,
    input wire logic core_start,
    input wire logic core_clk_tick,
    input wire logic [ADCC_CH_W-1:0] input_channel_select,
    // Base level; the result is this plus the selected channel index
    input wire logic [ADCC_RES_W-1:0] sample_base,
    // Answer
    output logic core_done,
    output logic [ADCC_RES_W-1:0] core_result
);
    logic busy;
    int count;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy <= 1'b0;
            count <= 0;
            core_done <= 1'b0;
            core_result <= '0;
        end
        else
        begin
            core_done <= 1'b0;
            // Result is only meaningful with done; keep it moving otherwise
            core_result <= ~core_result;
            if (!converter_on)
                busy <= 1'b0;
            else if (core_start)
            begin
                busy <= 1'b1;
                count <= 0;
            end
            else if (busy && core_clk_tick)
            begin
                if (count == TICKS - 1)
                begin
                    busy <= 1'b0;
                    core_done <= 1'b1;
                    core_result <= sample_base + {6'h00, input_channel_select};
                end
                else
                    count <= count + 1;
            end
        end
    end
endmodule // adcc_core_model

// >>> verification/tb.sv
`timescale 1ns/1ps

module tb;
    import adcc_pkg::*;
    // ****
    // Signals
    // ****
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic converter_on, core_start, core_clk_tick, core_channel_valid;
    logic core_done;
    logic [3:0] input_channel_select;
    logic [9:0] core_result, base, last;
    wire hready;
    int fails, comparisons;

    assign hready = hreadyout;

    adcc_regs #(.NUM_CH(8)) adcc_regs_i (.hclk(hclk), .hresetn(hresetn),
        .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .converter_on(converter_on), .core_start(core_start),
        .core_clk_tick(core_clk_tick),
        .input_channel_select(input_channel_select),
        .core_channel_valid(core_channel_valid), .core_done(core_done),
        .core_result(core_result));

    adcc_core_model adcc_core_model_i (.hclk(hclk), .hresetn(hresetn),
        .converter_on(converter_on), .core_start(core_start),
        .core_clk_tick(core_clk_tick),
        .input_channel_select(input_channel_select), .sample_base(base),
        .core_done(core_done), .core_result(core_result));

    // ****
    // Helpers
    // ****
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int n;
        n = 0;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 100)
        begin
            @(posedge hclk);
            n++;
        end
        rd = hrdata;
        chk("bus ready", 1'b1, hready);
        chk("bus response", 1'b0, hresp);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
        input string what);
        xfer(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rdchk(ADCC_OFF_CSR, 32'h0, "csr");
        rdchk(ADCC_OFF_HIGH, 32'h0, "high");
        rdchk(ADCC_OFF_LOW, 32'h0, "low");
        xfer(1'b1, 8'h14, 32'hff);
        rdchk(8'h14, 32'h0, "unmapped");
    endtask

    task automatic t_fields();
        xfer(1'b1, ADCC_OFF_CSR, 32'h4f);
        rdchk(ADCC_OFF_CSR, 32'h4f, "csr rw");
        xfer(1'b1, ADCC_OFF_CSR, 32'h80);
        rdchk(ADCC_OFF_CSR, 32'h0, "csr ro");
        for (int i = 0; i < 16; i++)
        begin
            xfer(1'b1, ADCC_OFF_CSR, i);
            @(posedge hclk);
            chk("select", i, input_channel_select);
            chk("valid", i < 8, core_channel_valid);
        end
    endtask

    task automatic t_conv(input logic speed, input logic [3:0] sel,
        input logic [9:0] b, input logic wclr);
        int n, gap;
        base = b;
        last = b + {6'h00, sel};
        xfer(1'b1, ADCC_OFF_IMR, !wclr);
        xfer(1'b1, ADCC_OFF_CSR, {speed, 2'b10, sel});
        n = 0;
        while (core_clk_tick !== 1'b1 && n < 20)
        begin
            @(posedge hclk);
            n++;
        end
        gap = 0;
        do
        begin
            @(posedge hclk);
            gap++;
        end
        while (core_clk_tick !== 1'b1 && gap < 20);
        chk("tick gap", speed ? 2 : 4, gap);
        n = 0;
        rd = 0;
        while (rd[7] !== 1'b1 && n < 40)
        begin
            xfer(1'b0, ADCC_OFF_CSR, 32'h0);
            n++;
        end
        chk("eoc", {speed, 2'b10, sel} | 8'h80, rd);
        chk("irq", !wclr, irq);
        rdchk(ADCC_OFF_LOW, last[1:0], "low");
        if (wclr)
        begin
            xfer(1'b1, ADCC_OFF_CSR, {speed, 2'b00, sel});
            rdchk(ADCC_OFF_CSR, {speed, 2'b00, sel}, "eoc wr");
        end
        else
        begin
            rdchk(ADCC_OFF_HIGH, last[9:2], "high");
            rdchk(ADCC_OFF_CSR, {speed, 2'b10, sel}, "eoc rd");
        end
        rdchk(ADCC_OFF_ISR, 32'h1, "isr");
        repeat (2) @(posedge hclk);
        chk("irq clr", 1'b0, irq);
        xfer(1'b1, ADCC_OFF_CSR, 32'h0);
    endtask

    task automatic t_abort();
        base = 10'h155;
        xfer(1'b1, ADCC_OFF_IMR, 32'h3);
        xfer(1'b1, ADCC_OFF_CSR, 32'h23);
        repeat (4) @(posedge hclk);
        xfer(1'b1, ADCC_OFF_CSR, 32'h03);
        chk("on", 1'b0, converter_on);
        repeat (60) @(posedge hclk);
        chk("tick", 1'b0, core_clk_tick);
        chk("irq", 1'b1, irq);
        rdchk(ADCC_OFF_CSR, 32'h03, "no eoc");
        rdchk(ADCC_OFF_HIGH, last[9:2], "high kept");
        rdchk(ADCC_OFF_LOW, last[1:0], "low kept");
        rdchk(ADCC_OFF_ISR, 32'h2, "isr abort");
    endtask

    // ****
    // Run
    // ****
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial
    begin
        #400000;
        fails++;
        end_of_test();
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        base = 10'h0;
        last = 10'h0;
        fails = 0;
        comparisons = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        hsel <= 1'b1;
        t_reset();
        t_fields();
        t_conv(1'b0, 4'h5, 10'h2c9, 1'b0);
        t_conv(1'b1, 4'hf, 10'h3f0, 1'b1);
        t_abort();
        end_of_test();
    end
endmodule // tb
